// ### src/dss_top.sv
// The AXI4-Lite interface to the registers and the address map were decided locally.
module dss_top
  import dss_pkg::*;
#(
  parameter int INIT_LEN  = INIT_CYCLES,
  parameter int SPEED_WIN = SPEED_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        safe_torque_chan_a,
  input  wire logic        safe_torque_chan_b,
  input  wire logic        start_cw_input,
  input  wire logic        start_ccw_input,
  input  wire logic        encoder_track_a_input,
  input  wire logic        encoder_track_b_input,
  input  wire logic        encoder_index_input,
  input  wire logic        multifunction_input_one,
  input  wire logic        extension_module,
  input  wire logic        dc_link_rising,
  input  wire logic        monitor_fault,
  input  wire logic [7:0]  monitor_code,
  output logic             power_stage_reg,
  output logic             fault_relay_output,
  output logic             run_status_output,
  output logic             standby_reg,
  output logic             error_reg,
  output logic [15:0]      freq_reg,
  output logic             multifunction_digital_path,
  output logic             multifunction_analog_path,
  output logic [31:0]      ext_speed_select_reg,
  output logic             irq_reg
);

  if (INIT_LEN < 1 || SPEED_WIN < 1) begin : g_bad_cnt
    $error("bad count parameter");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [8:0] pin_async;
  logic [8:0] meta_reg;
  logic [8:0] sync_reg;
  logic [8:0] prev_reg;
  assign pin_async = {multifunction_input_one, extension_module, encoder_index_input,
                      encoder_track_b_input, encoder_track_a_input, start_ccw_input,
                      start_cw_input, safe_torque_chan_b, safe_torque_chan_a};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 9'h0;
      sync_reg <= 9'h0;
      prev_reg <= 9'h0;
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  logic en_a;
  logic en_b;
  logic enc1_on;
  logic enables;
  logic cw_rise;
  logic ccw_rise;
  logic [3:0] enc1_mode;
  assign en_a    = sync_reg[0];
  assign en_b    = sync_reg[1];
  assign enables = en_a && en_b;
  assign enc1_on = (enc1_mode != ENC_OFF);
  // Inputs four to six serve the encoder alone once it is on.
  assign cw_rise  = sync_reg[2] && !prev_reg[2];
  assign ccw_rise = sync_reg[3] && !prev_reg[3];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [19:0] accel_reg;
  logic [19:0] decel_reg;
  logic [15:0] minfreq_reg;
  logic [31:0] enc_reg;
  logic [7:0]  errcode_reg;
  logic [3:0]  irq_stat_reg;
  logic [3:0]  irq_mask_reg;
  logic [7:0]  aw_addr_reg;
  logic        aw_full_reg;
  logic [31:0] w_data_reg;
  logic        w_full_reg;
  logic [31:0] speed1;
  logic [31:0] speed2;
  logic        dir1;
  logic        dir2;
  logic [3:0]  events;
  logic        wr_go;
  logic [13:0] marks1;
  logic [3:0]  enc2_mode;
  dss_state_type state_reg;
  logic        dir_reg;

  assign enc1_mode = enc_reg[ENC1_MODE_LSB +: 4];
  assign enc2_mode = enc_reg[ENC2_MODE_LSB +: 4];
  assign marks1    = enc_reg[ENC_MARKS_LSB +: 14];
  assign wr_go     = aw_full_reg && w_full_reg && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  logic [31:0] wm;
  logic [3:0]  w_strb_reg;
  always_comb begin
    wm = 32'h0;
    case (aw_addr_reg)
      ADDR_CTRL:     wm = merge(ctrl_reg, w_data_reg, w_strb_reg);
      ADDR_ACCEL:    wm = merge({12'h0, accel_reg}, w_data_reg, w_strb_reg);
      ADDR_DECEL:    wm = merge({12'h0, decel_reg}, w_data_reg, w_strb_reg);
      ADDR_MINFREQ:  wm = merge({16'h0, minfreq_reg}, w_data_reg, w_strb_reg);
      ADDR_ENC:      wm = merge(enc_reg, w_data_reg, w_strb_reg);
      default:       wm = merge(32'h0, w_data_reg, w_strb_reg);
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      aw_addr_reg <= 8'h0;
      w_data_reg  <= 32'h0;
      w_strb_reg  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg <= ADDR_IRQ_MASK) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg    <= {26'h0, 1'b1, 1'b1, SRC_BASE, MFI_VOLTAGE};
      accel_reg   <= RATE_DEFAULT;
      decel_reg   <= RATE_DEFAULT;
      minfreq_reg <= MIN_FREQ_VF;
      enc_reg     <= {16'h0, 2'b00, MARKS_DEFAULT};
      irq_mask_reg <= 4'h0;
    end else if (wr_go) begin
      case (aw_addr_reg)
        ADDR_CTRL: begin
          ctrl_reg <= wm;
          // Extension source only when the module is fitted.
          if (wm[CTRL_SRC_LSB +: 2] == SRC_EXT && !sync_reg[7]) begin
            ctrl_reg[CTRL_SRC_LSB +: 2] <= ctrl_reg[CTRL_SRC_LSB +: 2];
          end
          if (wm[CTRL_CFG_BIT] != ctrl_reg[CTRL_CFG_BIT]) begin
            minfreq_reg <= wm[CTRL_CFG_BIT] ? MIN_FREQ_VF : MIN_FREQ_ZERO;
          end
        end
        ADDR_ACCEL:   accel_reg <= (wm[19:0] > RATE_MAX) ? RATE_MAX : wm[19:0];
        ADDR_DECEL:   decel_reg <= (wm[19:0] > RATE_MAX) ? RATE_MAX : wm[19:0];
        ADDR_MINFREQ: minfreq_reg <= wm[15:0];
        ADDR_ENC: begin
          enc_reg <= wm;
          if (wm[13:0] < MARKS_MIN || wm[13:0] > MARKS_MAX) begin
            enc_reg[13:0] <= enc_reg[13:0];
          end
        end
        ADDR_IRQ_MASK: irq_mask_reg <= wm[3:0];
        default: ;
      endcase
    end else begin
      ctrl_reg[CTRL_INIT_BIT]  <= 1'b0;
      ctrl_reg[CTRL_FAULT_BIT] <= 1'b0;
    end
  end

  // Interrupt status: set wins over write-one-to-clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 4'h0;
      irq_reg      <= 1'b0;
    end else begin
      if (wr_go && aw_addr_reg == ADDR_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~wm[3:0]) | events;
      end else begin
        irq_stat_reg <= irq_stat_reg | events;
      end
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  logic [31:0] rd;
  always_comb begin
    case (s_axi_araddr & 8'hfc)
      ADDR_CTRL:     rd = ctrl_reg;
      ADDR_ACCEL:    rd = {12'h0, accel_reg};
      ADDR_DECEL:    rd = {12'h0, decel_reg};
      ADDR_MINFREQ:  rd = {16'h0, minfreq_reg};
      ADDR_ENC:      rd = enc_reg;
      ADDR_ERRCODE:  rd = {24'h0, errcode_reg};
      ADDR_STATUS:   rd = {26'h0, multifunction_digital_path, dir_reg,
                           power_stage_reg, error_reg, run_status_output, standby_reg};
      ADDR_FREQ:     rd = {16'h0, freq_reg};
      ADDR_SPEED:    rd = ext_speed_select_reg;
      ADDR_IRQ_STAT: rd = {28'h0, irq_stat_reg};
      ADDR_IRQ_MASK: rd = {28'h0, irq_mask_reg};
      default:       rd = 32'h0;
    endcase
  end


  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd;
      s_axi_rresp  <= ((s_axi_araddr & 8'hfc) <= ADDR_IRQ_MASK) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------------------------------
  // Drive sequencing
  // ----------------------------------------------------------------
  logic [31:0] init_cnt_reg;
  logic [15:0] tick_reg;
  logic [19:0] acc_frac_reg;
  logic [15:0] target;
  logic        tick;
  logic [19:0] rate;
  logic        want_run_reg;
  logic        fault_in;
  assign fault_in = monitor_fault || ctrl_reg[CTRL_FAULT_BIT];
  assign tick     = (tick_reg == 16'(TICK_CYCLES - 1));
  assign target   = want_run_reg ? minfreq_reg : 16'h0;
  assign rate     = (freq_reg < target) ? accel_reg : decel_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= DSS_INIT;
      init_cnt_reg <= 32'h0;
      want_run_reg <= 1'b0;
      dir_reg      <= 1'b0;
      power_stage_reg <= 1'b0;
      errcode_reg  <= 8'h0;
    end else begin
      case (state_reg)
        DSS_INIT: begin
          power_stage_reg <= 1'b0;
          want_run_reg    <= 1'b0;
          init_cnt_reg    <= init_cnt_reg + 32'h1;
          if (init_cnt_reg == 32'(INIT_LEN - 1)) state_reg <= DSS_STANDBY;
        end
        DSS_STANDBY: begin
          if (enables && (cw_rise || ccw_rise)) begin
            state_reg       <= DSS_RUN;
            want_run_reg    <= 1'b1;
            power_stage_reg <= 1'b1;
            dir_reg         <= ccw_rise && !cw_rise;
          end
        end
        DSS_RUN: begin
          if (!enables) begin
            state_reg       <= DSS_STANDBY;
            want_run_reg    <= 1'b0;
            power_stage_reg <= 1'b0;
          end
        end
        default: begin
          power_stage_reg <= 1'b0;
          want_run_reg    <= 1'b0;
        end
      endcase
      if (fault_in) begin
        state_reg       <= DSS_FAULT;
        power_stage_reg <= 1'b0;
        errcode_reg     <= monitor_fault ? monitor_code : CODE_ERROR_INT;
      end
      if (ctrl_reg[CTRL_INIT_BIT]) begin
        state_reg    <= DSS_INIT;
        init_cnt_reg <= 32'h0;
        errcode_reg  <= 8'h0;
      end
    end
  end

  // Rate integrator in 0.01 Hz per tick; slow regeneration stretches decel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_reg     <= 16'h0;
      acc_frac_reg <= 20'h0;
      freq_reg     <= 16'h0;
    end else begin
      tick_reg <= tick ? 16'h0 : tick_reg + 16'h1;
      if (!power_stage_reg) begin
        freq_reg     <= 16'h0;
        acc_frac_reg <= 20'h0;
      end else if (tick && freq_reg != target) begin
        if (!(freq_reg > target && ctrl_reg[CTRL_VC_BIT] && dc_link_rising)) begin
          if (acc_frac_reg + rate >= 20'(TICKS_PER_SEC)) begin
            acc_frac_reg <= 20'(acc_frac_reg + rate - 20'(TICKS_PER_SEC));
            freq_reg     <= (freq_reg < target) ? freq_reg + 16'h1 : freq_reg - 16'h1;
          end else begin
            acc_frac_reg <= acc_frac_reg + rate;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      standby_reg        <= 1'b0;
      run_status_output  <= 1'b0;
      error_reg          <= 1'b0;
      fault_relay_output <= 1'b0;
      multifunction_digital_path <= 1'b0;
      multifunction_analog_path  <= 1'b0;
      ext_speed_select_reg <= 32'h0;
    end else begin
      standby_reg       <= (state_reg != DSS_INIT) && (state_reg != DSS_FAULT);
      run_status_output <= (state_reg == DSS_RUN) && (freq_reg != 16'h0);
      error_reg         <= (state_reg == DSS_FAULT);
      // Inverted error: relay energised means healthy, so init reads as fault.
      fault_relay_output <= (state_reg == DSS_STANDBY) || (state_reg == DSS_RUN);
      multifunction_digital_path <= (ctrl_reg[CTRL_MFI_LSB +: 2] == MFI_DIGITAL)
                                    && sync_reg[8];
      multifunction_analog_path  <= (ctrl_reg[CTRL_MFI_LSB +: 2] == MFI_VOLTAGE)
                                    || (ctrl_reg[CTRL_MFI_LSB +: 2] == MFI_CURRENT);
      ext_speed_select_reg <= (ctrl_reg[CTRL_SRC_LSB +: 2] == SRC_EXT) ? speed2 : speed1;
    end
  end

  assign events = {state_reg == DSS_INIT, state_reg != DSS_FAULT && fault_in,
                   state_reg == DSS_RUN && !enables,
                   state_reg == DSS_STANDBY && enables && (cw_rise || ccw_rise)};

  // ----------------------------------------------------------------
  // Speed sensing
  // ----------------------------------------------------------------
  dss_encoder #(.WIN_CYCLES(SPEED_WIN)) u_enc1 (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .enable    (enc1_on),
    .track_a   (sync_reg[4]),
    .track_b   (sync_reg[5]),
    .track_z   (sync_reg[6]),
    .marks     (marks1),
    .speed_reg (speed1),
    .dir_reg   (dir1)
  );

  // Extension sensor data arrive elsewhere; decoder is parked off.
  assign speed2 = (enc2_mode != ENC_OFF && enc_reg[ENC2_LEVEL_BIT]) ? 32'h0 : 32'h0;
  assign dir2   = 1'b0;

endmodule

// ### src/dss_pkg.sv
// Behaviour
// - Frequency slews at accel/decel 0.00 to 9999.99 Hz/s, default 5.00; code steps at most 0.01 Hz per tick, so 1000.00 Hz/s.
// - Voltage controller may stretch deceleration while DC link rises.
// - Multifunction mode 1 voltage, 2 current, 3 digital.
// - Leaving commissioning reinitializes; fault relay reports fault meanwhile.
// - Both enables plus rising start edge accelerate to minimum frequency.
// - Minimum frequency default 3.50 Hz for V/f and field-oriented, else 0.00.
// - Standby asserts once initialization is finished.
// - Run asserts while started and frequency produced.
// - Error asserts on monitored fault; fault code kept.
// - Dropping either enable deactivates the power stage.
// - Speed source 1 base encoder, 2 extension only if fitted.
// - Division marks 1 to 8192, default 1024.
// - Nonzero base encoder mode claims inputs four to six.
// - Encoder mode 0 is off; its settings are ignored.
package dss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_ACCEL    = 8'h04;
  localparam logic [7:0] ADDR_DECEL    = 8'h08;
  localparam logic [7:0] ADDR_MINFREQ  = 8'h0c;
  localparam logic [7:0] ADDR_ENC      = 8'h10;
  localparam logic [7:0] ADDR_ERRCODE  = 8'h14;
  localparam logic [7:0] ADDR_STATUS   = 8'h18;
  localparam logic [7:0] ADDR_FREQ     = 8'h1c;
  localparam logic [7:0] ADDR_SPEED    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h28;

  // CTRL fields
  localparam int CTRL_MFI_LSB   = 0;
  localparam int CTRL_SRC_LSB   = 2;
  localparam int CTRL_VC_BIT    = 4;
  localparam int CTRL_CFG_BIT   = 5;
  localparam int CTRL_INIT_BIT  = 8;
  localparam int CTRL_FAULT_BIT = 9;
  // ENC fields
  localparam int ENC_MARKS_LSB  = 0;
  localparam int ENC1_MODE_LSB  = 16;
  localparam int ENC2_MODE_LSB  = 20;
  localparam int ENC2_LEVEL_BIT = 24;
  // STATUS bits
  localparam int ST_STANDBY = 0;
  localparam int ST_RUN     = 1;
  localparam int ST_ERROR   = 2;
  localparam int ST_STAGE   = 3;
  localparam int ST_DIR     = 4;
  localparam int ST_MFI_DIG = 5;
  // Interrupt events
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP  = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_READY = 3;

  // Frequencies in units of 0.01 Hz, rates in 0.01 Hz/s.
  localparam logic [19:0] RATE_MAX      = 20'hf423f;
  localparam logic [19:0] RATE_DEFAULT  = 20'h001f4;
  localparam logic [15:0] MIN_FREQ_VF   = 16'h015e;
  localparam logic [15:0] MIN_FREQ_ZERO = 16'h0000;
  localparam logic [13:0] MARKS_MIN     = 14'h0001;
  localparam logic [13:0] MARKS_MAX     = 14'h2000;
  localparam logic [13:0] MARKS_DEFAULT = 14'h0400;

  localparam logic [1:0] MFI_VOLTAGE = 2'h1;
  localparam logic [1:0] MFI_CURRENT = 2'h2;
  localparam logic [1:0] MFI_DIGITAL = 2'h3;
  localparam logic [1:0] SRC_BASE    = 2'h1;
  localparam logic [1:0] SRC_EXT     = 2'h2;
  localparam logic [3:0] ENC_OFF     = 4'h0;

  localparam logic [7:0] CODE_STANDBY_INT = 8'ha0;
  localparam logic [7:0] CODE_RUN_INT     = 8'ha1;
  localparam logic [7:0] CODE_ERROR_INT   = 8'ha2;
  localparam logic [7:0] CODE_INV_ERROR   = 8'h67;

  // Timing
  localparam int CLK_MHZ        = 250;
  localparam int TICK_US        = 10;
  localparam int TICK_CYCLES    = CLK_MHZ * TICK_US;
  localparam int INIT_US        = 100;
  localparam int INIT_CYCLES    = CLK_MHZ * INIT_US;
  localparam int SPEED_WIN_MS   = 10;
  localparam int SPEED_CYCLES   = CLK_MHZ * 1000 * SPEED_WIN_MS;
  localparam int TICKS_PER_SEC  = 1000000 / TICK_US;

  typedef enum logic [1:0] {
    DSS_INIT    = 2'b00,
    DSS_STANDBY = 2'b01,
    DSS_RUN     = 2'b11,
    DSS_FAULT   = 2'b10
  } dss_state_type;

endpackage

// ### src/dss_encoder.sv
module dss_encoder
  import dss_pkg::*;
#(
  parameter int WIN_CYCLES = SPEED_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        enable,
  input  wire logic        track_a,
  input  wire logic        track_b,
  input  wire logic        track_z,
  input  wire logic [13:0] marks,
  output logic      [31:0] speed_reg,
  output logic             dir_reg
);

  if (WIN_CYCLES < 1) begin : g_bad_win
    $error("window too short");
  end

  logic [31:0] win_reg;
  logic [31:0] edge_reg;
  logic        a_reg;
  logic        b_reg;
  logic [3:0]  step;

  assign step = {a_reg, b_reg, track_a, track_b};

  // ----------------------------------------------------------------
  // Quadrature decode and window count
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_reg    <= 1'b0;
      b_reg    <= 1'b0;
      edge_reg <= 32'h0;
      win_reg  <= 32'h0;
      speed_reg <= 32'h0;
      dir_reg  <= 1'b0;
    end else begin
      a_reg <= track_a;
      b_reg <= track_b;
      if (!enable) begin
        edge_reg  <= 32'h0;
        win_reg   <= 32'h0;
        speed_reg <= 32'h0;
      end else begin
        case (step)
          4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
            edge_reg <= edge_reg + 32'h1;
            dir_reg  <= 1'b0;
          end
          4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
            edge_reg <= edge_reg + 32'h1;
            dir_reg  <= 1'b1;
          end
          default: begin
            edge_reg <= edge_reg;
          end
        endcase
        if (win_reg == 32'(WIN_CYCLES - 1)) begin
          win_reg <= 32'h0;
          // Quarter-lines per window times 25, divided by marks; index track is not used at all.
          speed_reg <= (edge_reg * 32'd25) / {18'h0, marks};
          edge_reg  <= 32'h0;
        end else begin
          win_reg <= win_reg + 32'h1;
        end
      end
    end
  end

  logic z_unused;
  assign z_unused = track_z;

endmodule

// ### tb/dss_checker.sv
module dss_checker
  import dss_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic safe_torque_chan_a,
  input wire logic safe_torque_chan_b,
  input wire logic start_cw_input,
  input wire logic monitor_fault,
  input wire logic power_stage_reg,
  input wire logic fault_relay_output,
  input wire logic run_status_output,
  input wire logic standby_reg,
  input wire logic error_reg,
  input wire logic multifunction_digital_path,
  input wire logic multifunction_analog_path
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic en2 = safe_torque_chan_a & safe_torque_chan_b;
  sequence cw_edge;
    en2 && !start_cw_input && standby_reg && !error_reg ##1 en2 && start_cw_input;
  endsequence
  stage_on_start_a: assert property (cw_edge ##1 en2 [*4] |-> ##[0:4] power_stage_reg)
    else $error("no stage after start");
  stage_off_a: assert property (!en2 [*4] |-> !power_stage_reg)
    else $error("stage on without enables");
  run_stage_a: assert property ($rose(run_status_output) |-> power_stage_reg)
    else $error("run without stage");
  mfi_excl_a: assert property (!(multifunction_analog_path && multifunction_digital_path))
    else $error("both input paths");
  err_set_a: assert property (monitor_fault && standby_reg |-> ##[1:3] error_reg)
    else $error("fault not flagged");
  relay_err_a: assert property (error_reg |-> ##[0:1] !fault_relay_output)
    else $error("relay healthy on error");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer moved");
endmodule

bind dss_top dss_checker i_dss_checker (.*);

// ### tb/dss_partner.sv
module dss_partner (
  input  wire logic aclk,
  input  wire logic en,
  input  wire logic spin,
  output logic      sto_a,
  output logic      sto_b,
  output logic      trk_a,
  output logic      trk_b,
  output logic      trk_z
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Switches and encoder
  // ----------------------------------------------------------------
  logic       en_q = 1'b0;
  logic [5:0] pos  = 6'h00;
  always @(posedge aclk) begin
    en_q <= en;
    if (spin) pos <= pos + 6'h01;
  end
  // Both channels follow one switch, so they never disagree here.
  assign sto_a = en_q;
  assign sto_b = en_q;
  assign trk_a = pos[3];
  assign trk_b = pos[3] ^ pos[2];
  assign trk_z = pos == 6'h00;
endmodule

// ### tb/tb_dss_top.sv
module tb_dss_top
  import dss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0, aresetn = 1'b0, en = 1'b0, spin = 1'b0, start_cw_input = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, extension_module = 1'b0;
  logic multifunction_input_one = 1'b0, monitor_fault = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, monitor_code = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, exp_q[$], msk_q[$];
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp_q[$];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic safe_torque_chan_a, safe_torque_chan_b, encoder_track_a_input, encoder_track_b_input;
  logic encoder_index_input, power_stage_reg, fault_relay_output, run_status_output;
  logic standby_reg, error_reg, multifunction_digital_path, multifunction_analog_path, irq_reg;
  int num_errors = 0, check_count = 0, cyc = 0, v;
  always #2 aclk = ~aclk;
  dss_partner i_dss_partner (.aclk, .en, .spin, .sto_a(safe_torque_chan_a),
    .sto_b(safe_torque_chan_b), .trk_a(encoder_track_a_input),
    .trk_b(encoder_track_b_input), .trk_z(encoder_index_input));
  dss_top #(.INIT_LEN(8), .SPEED_WIN(16)) i_dss_top (.*, .s_axi_wstrb(4'hf),
    .start_ccw_input(1'b0), .dc_link_rising(1'b0), .freq_reg(), .ext_speed_select_reg());
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic bad(input string s);
    num_errors++;
    $display("BAD %0t %s", $time, s);
  endtask
  task automatic chk(input logic c, input string s);
    check_count++;
    if (c !== 1'b1) bad(s);
  endtask
  task automatic complete_run;
    if (num_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp == 2'b00, "bresp");
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r);
    exp_q.push_back(e);
    msk_q.push_back(m);
    rsp_q.push_back(r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad("timeout");
      complete_run;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      check_count++;
      if (exp_q.size() == 0) bad("unexpected read");
      else if ((s_axi_rdata & msk_q[0]) !== (exp_q[0] & msk_q[0]) || s_axi_rresp !== rsp_q[0])
        bad("read mismatch");
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
      void'(rsp_q.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(42125));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_CTRL, 32'h35, 32'h3f, 2'h0);
    rd(ADDR_ACCEL, 32'(RATE_DEFAULT), 32'hfffff, 2'h0);
    rd(ADDR_DECEL, 32'(RATE_DEFAULT), 32'hfffff, 2'h0);
    rd(ADDR_MINFREQ, 32'(MIN_FREQ_VF), 32'hffff, 2'h0);
    rd(ADDR_ENC, 32'(MARKS_DEFAULT), 32'h3fff, 2'h0);
    rd(8'h2c, 32'h0, 32'hffffffff, 2'h2);
    wr(ADDR_ENC, 32'h0);
    rd(ADDR_ENC, 32'(MARKS_DEFAULT), 32'h3fff, 2'h0);
    v = $urandom_range(8192, 1);
    wr(ADDR_ENC, 32'h10000 | 32'(v));
    rd(ADDR_ENC, 32'h10000 | 32'(v), 32'hf3fff, 2'h0);
    wr(ADDR_ACCEL, 32'hfffff);
    rd(ADDR_ACCEL, 32'(RATE_MAX), 32'hfffff, 2'h0);
    wr(ADDR_DECEL, 32'h0);
    rd(ADDR_DECEL, 32'h0, 32'hfffff, 2'h0);
    wr(ADDR_CTRL, 32'h39);
    rd(ADDR_CTRL, 32'h04, 32'h0c, 2'h0);
    extension_module <= 1'b1;
    repeat (4) @(posedge aclk);
    wr(ADDR_CTRL, 32'h39);
    rd(ADDR_CTRL, 32'h08, 32'h0c, 2'h0);
    wr(ADDR_CTRL, 32'h37);
    multifunction_input_one <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(multifunction_digital_path, "digital path");
    chk(standby_reg, "standby");
    en <= 1'b1;
    spin <= 1'b1;
    repeat (4) @(posedge aclk);
    start_cw_input <= 1'b1;
    for (int i = 0; i < 6000 && run_status_output !== 1'b1; i++) @(posedge aclk);
    chk(run_status_output, "run");
    rd(ADDR_STATUS, 32'h0a, 32'h0a, 2'h0);
    en <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(!power_stage_reg, "stage stays on");
    wr(ADDR_IRQ_MASK, 32'h0);
    monitor_code <= 8'($urandom);
    monitor_fault <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(error_reg, "error");
    monitor_fault <= 1'b0;
    chk(!irq_reg, "masked irq");
    rd(ADDR_ERRCODE, 32'(monitor_code), 32'hff, 2'h0);
    wr(ADDR_IRQ_MASK, 32'h4);
    repeat (2) @(posedge aclk);
    chk(irq_reg, "irq");
    wr(ADDR_IRQ_STAT, 32'hf);
    repeat (2) @(posedge aclk);
    chk(!irq_reg, "irq clear");
    complete_run;
  end
endmodule
